//--- hdl/sfpi_pkg.sv
// Shared constants and types for the serial flash pin interface
package sfpi_pkg;
	// Timing
	localparam int CLK_NS = 25;
	localparam int RST_MIN_NS = 1000;
	localparam logic [5:0] RST_MIN_CYC = 6'((RST_MIN_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [5:0] RST_HOLD_CYC = 6'(RST_MIN_CYC + 6'h08);
	localparam int SCLK_NS = 200;
	localparam logic [2:0] HALF_CYC = 3'(SCLK_NS / 2 / CLK_NS);
	localparam logic [2:0] SAMPLE_AT = 3'h2;
	// Wide-lane opcodes
	localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
	localparam logic [7:0] OP_DUAL_IO = 8'hBB;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
	localparam logic [7:0] OP_QUAD_IO = 8'hEB;
	// Controller register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TXD = 8'h04;
	localparam logic [7:0] REG_RXD = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;
	localparam logic [7:0] REG_PIN = 8'h10;
	// Field positions
	localparam int CTRL_GO = 0;
	localparam int CTRL_WID = 1;
	localparam int CTRL_RD = 3;
	localparam int CTRL_KEEP = 4;
	localparam int CTRL_CPOL = 5;
	localparam int PIN_WP = 0;
	localparam int PIN_HOLD = 1;
	localparam int PIN_RST = 2;
	// Reset values
	localparam logic [1:0] PIN_RESET = 2'h3;
	localparam logic [7:0] TXD_RESET = 8'h00;

	typedef enum logic [1:0] {W1 = 2'h0, W2 = 2'h1, W4 = 2'h2} sfpi_width_t;

	// Bits moved per clock edge
	function automatic logic [2:0] sfpi_step(input sfpi_width_t w);
		unique case (w)
			W2: return 3'h2;
			W4: return 3'h4;
			default: return 3'h1;
		endcase
	endfunction

	// Lanes used by a width
	function automatic logic [3:0] sfpi_mask(input sfpi_width_t w);
		unique case (w)
			W2: return 4'h3;
			W4: return 4'hF;
			default: return 4'h1;
		endcase
	endfunction
endpackage

//--- hdl/sfpi_if.sv
// Pin bundle between flash device end and host controller end
`timescale 1ns/10ps
`default_nettype none
interface sfpi_if;
	logic sclk;
	logic cs_n;
	logic rst_n;
	logic [3:0] host_lane_out;
	logic [3:0] host_lane_oe_n;
	logic [3:0] dev_lane_out;
	logic [3:0] dev_lane_oe_n;
	logic [3:0] lane;

	// Wire level per lane, pulled up when nobody drives
	assign lane = (~dev_lane_oe_n & dev_lane_out) | (~host_lane_oe_n & host_lane_out) | (dev_lane_oe_n & host_lane_oe_n);

	modport device (input sclk, input cs_n, input rst_n, input lane, output dev_lane_out, output dev_lane_oe_n);
	modport host (output sclk, output cs_n, output rst_n, output host_lane_out, output host_lane_oe_n, input lane);
endinterface
`default_nettype wire

//--- hdl/sfpi_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module sfpi_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_r;

	// First stage feeds only the second
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_r <= INIT;
			q_out <= INIT;
		end else begin
			meta_r <= d_in;
			q_out <= meta_r;
		end
	end
endmodule // sfpi_sync
`default_nettype wire

//--- hdl/sfpi_device.sv
// Flash-side pin front end: select, lanes, hold, protect, pin reset
//
// Operation
// - Deselected: all lanes float.
// - First instruction needs a select falling edge.
// - Single mode samples serial_in on rising edge.
// - Single mode drives output on falling edge.
// - Wide modes: in on rise, out on fall.
// - Quad needs quad_enable_bit; lanes two, three.
// - Write-protect pin with protect bits locks.
// - Hold low while selected: float, ignore clock.
// - Hold released: operation resumes where paused.
// - quad_enable_bit set disables hold entirely.
// - Reset pin low one microsecond aborts all.
// - Reset pin works in any state.
// - Clock modes 0 and 3 supported.
// - Dual opcodes use lanes zero and one.
// - Quad opcodes use all four lanes.
// - Hold only honoured outside quad operation.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module sfpi_device (
	input wire logic clock_in,
	input wire logic nrst_in,
	sfpi_if.device pins,
	input wire logic quad_enable_bit_in,
	input wire logic status_protect_bit_in,
	input wire logic complement_protect_in,
	input wire logic small_region_select_in,
	input wire logic top_bottom_select_in,
	input wire logic block_protect_level_2_in,
	input wire logic block_protect_level_1_in,
	input wire logic block_protect_level_0_in,
	input wire logic tx_en_in,
	input wire logic [7:0] tx_data_in,
	output logic [7:0] opcode_out,
	output logic opcode_valid_out,
	output logic [7:0] rx_data_out,
	output logic rx_valid_out,
	output logic tx_take_out,
	output logic selected_out,
	output logic held_out,
	output logic pin_reset_out,
	output logic status_write_locked_out,
	output logic [5:0] region_scope_out
);
	import sfpi_pkg::*;

	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_OPC = 4'h2,
		S_DATA = 4'h4,
		S_SKIP = 4'h8
	} sfpi_dstate_t;

	sfpi_dstate_t state_r;
	sfpi_dstate_t state_nxt;
	logic [6:0] pin_s;
	logic rst_pin_s;
	logic cs_s;
	logic sclk_s;
	logic [3:0] lane_s;
	logic sclk_q_r;
	logic [5:0] rst_cnt_r;
	logic hw_rst_r;
	logic armed_r;
	logic held;
	logic rise;
	logic fall;
	logic [2:0] rx_cnt_r;
	logic [2:0] rx_cnt_nxt;
	logic [7:0] rx_sr_r;
	logic [7:0] rx_sr_nxt;
	logic byte_done;
	sfpi_width_t in_w_r;
	sfpi_width_t out_w_r;
	logic [2:0] tx_cnt_r;
	logic [7:0] tx_sr_r;
	logic drive_r;
	logic [3:0] lane_o_r;
	logic drive;
	logic wp_n;

	// Pin synchroniser: reset, select, clock, lanes
	sfpi_sync #(.W(7), .INIT(7'h6F)) u_pin_sync (
		.clock_in(clock_in),
		.nrst_in(nrst_in),
		.d_in({pins.rst_n, pins.cs_n, pins.sclk, pins.lane}),
		.q_out(pin_s)
	);
	assign rst_pin_s = pin_s[6];
	assign cs_s = pin_s[5];
	assign sclk_s = pin_s[4];
	assign lane_s = pin_s[3:0];

	// Hold honoured only when lane three is not a data lane
	assign held = ~cs_s & ~state_r[0] & ~lane_s[3] & ~quad_enable_bit_in;
	// Clock edges, frozen while held
	assign rise = sclk_s & ~sclk_q_r & ~cs_s & ~held;
	assign fall = ~sclk_s & sclk_q_r & ~cs_s & ~held;

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sclk_q_r <= 1'h0;
		end else begin
			sclk_q_r <= sclk_s;
		end
	end

	// Reset pin filter: must stay low the minimum time
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_cnt_r <= 6'h00;
			hw_rst_r <= 1'h0;
		end else if (rst_pin_s) begin
			rst_cnt_r <= 6'h00;
			hw_rst_r <= 1'h0;
		end else begin
			if (rst_cnt_r != RST_MIN_CYC) begin
				rst_cnt_r <= rst_cnt_r + 6'h01;
			end
			hw_rst_r <= (rst_cnt_r == RST_MIN_CYC);
		end
	end

	// Select must be seen high before a frame may start
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			armed_r <= 1'h0;
		end else if (hw_rst_r) begin
			armed_r <= 1'h0;
		end else if (cs_s) begin
			armed_r <= 1'h1;
		end
	end

	// Next receive shift value per inbound width
	always_comb begin
		unique case (in_w_r)
			W2: rx_sr_nxt = {rx_sr_r[5:0], lane_s[1:0]};
			W4: rx_sr_nxt = {rx_sr_r[3:0], lane_s};
			default: rx_sr_nxt = {rx_sr_r[6:0], lane_s[0]};
		endcase
	end
	assign rx_cnt_nxt = 3'(rx_cnt_r + sfpi_step(in_w_r));
	assign byte_done = rise & (rx_cnt_nxt == 3'h0);

	// Frame sequencing
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			S_IDLE: begin
				if (~cs_s & armed_r) begin
					state_nxt = S_OPC;
				end
			end
			S_OPC: begin
				if (byte_done) begin
					if ((rx_sr_nxt == OP_QUAD_OUT || rx_sr_nxt == OP_QUAD_IO) && !quad_enable_bit_in) begin
						state_nxt = S_SKIP;
					end else begin
						state_nxt = S_DATA;
					end
				end
			end
			S_DATA, S_SKIP: state_nxt = state_r;
		endcase
		if (cs_s) begin
			state_nxt = S_IDLE;
		end
	end

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_r <= S_IDLE;
		end else if (hw_rst_r) begin
			state_r <= S_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Receive shifter, opcode decode, byte delivery
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rx_cnt_r <= 3'h0;
			rx_sr_r <= 8'h00;
			in_w_r <= W1;
			out_w_r <= W1;
			opcode_out <= 8'h00;
			opcode_valid_out <= 1'h0;
			rx_data_out <= 8'h00;
			rx_valid_out <= 1'h0;
		end else begin
			opcode_valid_out <= 1'h0;
			rx_valid_out <= 1'h0;
			if (hw_rst_r || state_r[0]) begin
				rx_cnt_r <= 3'h0;
				in_w_r <= W1;
				out_w_r <= W1;
			end else if (rise && !state_r[3]) begin
				rx_cnt_r <= rx_cnt_nxt;
				rx_sr_r <= rx_sr_nxt;
				if (byte_done && state_r[1]) begin
					opcode_out <= rx_sr_nxt;
					opcode_valid_out <= 1'h1;
					unique case (rx_sr_nxt)
						OP_DUAL_OUT: out_w_r <= W2;
						OP_DUAL_IO: begin
							in_w_r <= W2;
							out_w_r <= W2;
						end
						OP_QUAD_OUT: out_w_r <= W4;
						OP_QUAD_IO: begin
							in_w_r <= W4;
							out_w_r <= W4;
						end
						default: out_w_r <= W1;
					endcase
				end else if (byte_done) begin
					rx_data_out <= rx_sr_nxt;
					rx_valid_out <= 1'h1;
				end
			end
		end
	end

	// Transmit shifter: loads or shifts on falling edges
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tx_cnt_r <= 3'h0;
			tx_sr_r <= 8'h00;
			drive_r <= 1'h0;
			tx_take_out <= 1'h0;
		end else begin
			tx_take_out <= 1'h0;
			if (hw_rst_r || !state_r[2]) begin
				tx_cnt_r <= 3'h0;
				drive_r <= 1'h0;
			end else if (fall && tx_en_in) begin
				drive_r <= 1'h1;
				if (tx_cnt_r == 3'h0) begin
					tx_sr_r <= tx_data_in;
					tx_take_out <= 1'h1;
					tx_cnt_r <= sfpi_step(out_w_r);
				end else begin
					tx_sr_r <= 8'(tx_sr_r << sfpi_step(out_w_r));
					tx_cnt_r <= 3'(tx_cnt_r + sfpi_step(out_w_r));
				end
			end
		end
	end

	// Lane data from the transmit shifter
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			lane_o_r <= 4'h0;
		end else begin
			unique case (out_w_r)
				W2: lane_o_r <= {2'h0, tx_sr_r[7:6]};
				W4: lane_o_r <= tx_sr_r[7:4];
				default: lane_o_r <= {2'h0, tx_sr_r[7], 1'h0};
			endcase
		end
	end

	// Drivers float when deselected, held or idle
	assign drive = drive_r & state_r[2] & ~cs_s & ~held;
	assign pins.dev_lane_out = lane_o_r;
	always_comb begin
		if (out_w_r == W1) begin
			pins.dev_lane_oe_n = ~({4{drive}} & 4'h2);
		end else begin
			pins.dev_lane_oe_n = ~({4{drive}} & sfpi_mask(out_w_r));
		end
	end

	// Hardware protection from write-protect pin
	assign wp_n = lane_s[2] | quad_enable_bit_in;
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			status_write_locked_out <= 1'h0;
			region_scope_out <= 6'h00;
		end else begin
			status_write_locked_out <= status_protect_bit_in & ~wp_n;
			if (status_protect_bit_in && !wp_n) begin
				region_scope_out <= {complement_protect_in, small_region_select_in, top_bottom_select_in,
					block_protect_level_2_in, block_protect_level_1_in, block_protect_level_0_in};
			end else begin
				region_scope_out <= 6'h00;
			end
		end
	end

	// Status
	assign selected_out = ~state_r[0];
	assign held_out = held;
	assign pin_reset_out = hw_rst_r;
endmodule // sfpi_device
`default_nettype wire

//--- hdl/sfpi_host.sv
// Host-side SPI controller driving clock, select, lanes and reset pin
`timescale 1ns/10ps
`default_nettype none
module sfpi_host (
	input wire logic clock_in,
	input wire logic nrst_in,
	sfpi_if.host pins,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out
);
	import sfpi_pkg::*;

	typedef enum logic [5:0] {
		H_IDLE = 6'h01,
		H_SEL = 6'h02,
		H_LOW = 6'h04,
		H_HIGH = 6'h08,
		H_END = 6'h10,
		H_GAP = 6'h20
	} sfpi_hstate_t;

	sfpi_hstate_t state_r;
	logic [2:0] half_r;
	logic half_end;
	logic [2:0] bit_r;
	logic [2:0] bit_nxt;
	sfpi_width_t wid_r;
	logic rd_r;
	logic keep_r;
	logic cpol_r;
	logic [7:0] txd_r;
	logic [7:0] tx_sr_r;
	logic [7:0] rx_sr_r;
	logic wp_r;
	logic hold_r;
	logic [5:0] rst_cnt_r;
	logic [3:0] lane_s;
	logic go;
	logic data_drv;
	logic pin_drv;

	sfpi_sync #(.W(4), .INIT(4'hF)) u_lane_sync (
		.clock_in(clock_in),
		.nrst_in(nrst_in),
		.d_in(pins.lane),
		.q_out(lane_s)
	);

	assign go = wr_in & (addr_in == REG_CTRL) & wdata_in[CTRL_GO] & (state_r == H_IDLE);
	assign half_end = (half_r == 3'(HALF_CYC - 3'h1));
	assign bit_nxt = 3'(bit_r + sfpi_step(wid_r));

	// Transfer sequencer
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_r <= H_IDLE;
			half_r <= 3'h0;
			bit_r <= 3'h0;
			pins.sclk <= 1'h0;
			pins.cs_n <= 1'h1;
			tx_sr_r <= 8'h00;
			rx_sr_r <= 8'h00;
		end else begin
			half_r <= half_end ? 3'h0 : 3'(half_r + 3'h1);
			unique case (state_r)
				H_IDLE: begin
					half_r <= 3'h0;
					if (!pins.cs_n) begin
						pins.sclk <= 1'h1;
					end else begin
						pins.sclk <= cpol_r;
					end
					if (go) begin
						tx_sr_r <= txd_r;
						bit_r <= 3'h0;
						if (pins.cs_n) begin
							pins.cs_n <= 1'h0;
							state_r <= H_SEL;
						end else begin
							pins.sclk <= 1'h0;
							state_r <= H_LOW;
						end
					end
				end
				H_SEL: begin
					if (half_end) begin
						pins.sclk <= 1'h0;
						state_r <= H_LOW;
					end
				end
				H_LOW: begin
					if (half_end) begin
						pins.sclk <= 1'h1;
						state_r <= H_HIGH;
					end
				end
				H_HIGH: begin
					if (half_r == SAMPLE_AT && rd_r) begin
						unique case (wid_r)
							W2: rx_sr_r <= {rx_sr_r[5:0], lane_s[1:0]};
							W4: rx_sr_r <= {rx_sr_r[3:0], lane_s};
							default: rx_sr_r <= {rx_sr_r[6:0], lane_s[1]};
						endcase
					end
					if (half_end) begin
						bit_r <= bit_nxt;
						if (bit_nxt != 3'h0) begin
							pins.sclk <= 1'h0;
							tx_sr_r <= 8'(tx_sr_r << sfpi_step(wid_r));
							state_r <= H_LOW;
						end else if (keep_r) begin
							state_r <= H_IDLE;
						end else begin
							pins.sclk <= cpol_r;
							state_r <= H_END;
						end
					end
				end
				H_END: begin
					if (half_end) begin
						pins.cs_n <= 1'h1;
						state_r <= H_GAP;
					end
				end
				H_GAP: begin
					if (half_end) begin
						state_r <= H_IDLE;
					end
				end
				default: state_r <= H_IDLE;
			endcase
		end
	end

	// Control and pin registers
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wid_r <= W1;
			rd_r <= 1'h0;
			keep_r <= 1'h0;
			cpol_r <= 1'h0;
			txd_r <= TXD_RESET;
			{hold_r, wp_r} <= PIN_RESET;
		end else if (wr_in) begin
			if (addr_in == REG_CTRL && state_r == H_IDLE) begin
				wid_r <= (wdata_in[CTRL_WID+1:CTRL_WID] == 2'h3) ? W4 : sfpi_width_t'(wdata_in[CTRL_WID+1:CTRL_WID]);
				rd_r <= wdata_in[CTRL_RD];
				keep_r <= wdata_in[CTRL_KEEP];
				cpol_r <= wdata_in[CTRL_CPOL];
			end
			if (addr_in == REG_TXD) begin
				txd_r <= wdata_in;
			end
			if (addr_in == REG_PIN) begin
				wp_r <= wdata_in[PIN_WP];
				hold_r <= wdata_in[PIN_HOLD];
			end
		end
	end

	// Reset pin pulse, held past the device minimum
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_cnt_r <= 6'h00;
			pins.rst_n <= 1'h1;
		end else begin
			if (wr_in && addr_in == REG_PIN && wdata_in[PIN_RST]) begin
				rst_cnt_r <= RST_HOLD_CYC;
			end else if (rst_cnt_r != 6'h00) begin
				rst_cnt_r <= rst_cnt_r - 6'h01;
			end
			pins.rst_n <= (rst_cnt_r == 6'h00);
		end
	end

	// Lane drive: data while writing, protect and hold levels otherwise, except at quad width where lanes two and three carry shifter bits
	assign data_drv = ~rd_r & (state_r == H_LOW || state_r == H_HIGH || state_r == H_SEL);
	// Quad lanes two and three stay released through the gap, until the device has floated them
	assign pin_drv = ~((~pins.cs_n | (state_r == H_GAP)) & (wid_r == W4));
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pins.host_lane_out <= 4'hF;
		end else begin
			unique case (wid_r)
				W2: pins.host_lane_out <= {hold_r, wp_r, tx_sr_r[7:6]};
				W4: pins.host_lane_out <= tx_sr_r[7:4];
				default: pins.host_lane_out <= {hold_r, wp_r, 1'h1, tx_sr_r[7]};
			endcase
		end
	end
	assign pins.host_lane_oe_n = ~(({4{data_drv}} & sfpi_mask(wid_r)) | {pin_drv, pin_drv, 2'h0});

	// Register read, data valid the cycle after the strobe
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			unique case (addr_in)
				REG_CTRL: rdata_out <= {2'h0, cpol_r, keep_r, rd_r, wid_r, 1'h0};
				REG_TXD: rdata_out <= txd_r;
				REG_RXD: rdata_out <= rx_sr_r;
				REG_STAT: rdata_out <= {5'h00, rst_cnt_r != 6'h00, ~pins.cs_n, state_r != H_IDLE};
				REG_PIN: rdata_out <= {5'h00, rst_cnt_r != 6'h00, hold_r, wp_r};
				default: rdata_out <= 8'h00;
			endcase
		end else begin
			rdata_out <= 8'h00;
		end
	end
endmodule // sfpi_host
`default_nettype wire

//--- tb/sfpi_monitor.sv
// Pin protocol checks between the flash end and the host end
`timescale 1ns/10ps
`default_nettype none
module sfpi_monitor (
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic rst_n,
	input wire logic [3:0] host_lane_oe_n,
	input wire logic [3:0] dev_lane_out,
	input wire logic [3:0] dev_lane_oe_n
);
	import sfpi_pkg::*;
	logic [5:0] low_cnt_r;
	logic [3:0] fall_cnt_r;
	logic sclk_d_r;
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!nrst_in);
	// Reset pin low length and cycles since sclk fell
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			low_cnt_r <= 6'h00;
			fall_cnt_r <= 4'hF;
			sclk_d_r <= 1'b0;
		end else begin
			sclk_d_r <= sclk;
			low_cnt_r <= rst_n ? 6'h00 : (low_cnt_r == 6'h3F ? low_cnt_r : low_cnt_r + 6'h01);
			if (sclk_d_r && !sclk) begin
				fall_cnt_r <= 4'h0;
			end else if (fall_cnt_r != 4'hF) begin
				fall_cnt_r <= fall_cnt_r + 4'h1;
			end
		end
	end
	property p_float_idle; cs_n [*4] |-> dev_lane_oe_n == 4'hF; endproperty
	a_float_idle: assert property (p_float_idle) else $error("device drives while deselected");
	property p_no_fight; (~dev_lane_oe_n & ~host_lane_oe_n) == 4'h0; endproperty
	a_no_fight: assert property (p_no_fight) else $error("both ends drive a lane");
	property p_out_on_fall;
		($stable(dev_lane_oe_n) && dev_lane_oe_n != 4'hF && $changed(dev_lane_out | dev_lane_oe_n))
			|-> fall_cnt_r inside {[2:6]};
	endproperty
	a_out_on_fall: assert property (p_out_on_fall) else $error("output changed away from falling edge");
	property p_cs_fall; $fell(cs_n) |-> $stable(sclk) ##1 $stable(sclk) [*2]; endproperty
	a_cs_fall: assert property (p_cs_fall) else $error("clock moved at select fall");
	property p_cs_rise; $rose(cs_n) |-> $stable(sclk) && $past(sclk, 2) == sclk; endproperty
	a_cs_rise: assert property (p_cs_rise) else $error("clock moved at select rise");
	property p_half; $changed(sclk) |=> $stable(sclk) [*3]; endproperty
	a_half: assert property (p_half) else $error("clock half period too short");
	property p_rst_len; $rose(rst_n) |-> low_cnt_r == RST_HOLD_CYC; endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset pin pulse length wrong");
	property p_rst_float; low_cnt_r == RST_HOLD_CYC |-> dev_lane_oe_n == 4'hF; endproperty
	a_rst_float: assert property (p_rst_float) else $error("device drives during pin reset");
	// Main scenarios reached
	c_frame: cover property ($fell(cs_n));
	c_dual: cover property (dev_lane_oe_n == 4'hC);
	c_quad: cover property (dev_lane_oe_n == 4'h0);
	c_rst: cover property ($rose(rst_n));
endmodule // sfpi_monitor
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench joining the flash end and the host end
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import sfpi_pkg::*;
	logic clock_in = 1'b0;
	logic nrst_in = 1'b0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic tx_en = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] tx_data = 8'h00;
	logic [7:0] cfg = 8'h00;
	logic [7:0] op_seen = 8'h00;
	logic [7:0] rx_seen = 8'h00;
	logic [7:0] rdata, rv, opcode, rx_data;
	logic op_valid, rx_valid, sel, held, pin_rst, locked, take;
	logic [5:0] scope;
	int rx_cnt = 0;
	int take_cnt = 0;
	int num_errors = 0;
	int cmp_count = 0;
	sfpi_if pins();
	sfpi_device i_sfpi_device (.clock_in(clock_in), .nrst_in(nrst_in), .pins(pins), .quad_enable_bit_in(cfg[7]),
		.status_protect_bit_in(cfg[6]), .complement_protect_in(cfg[5]), .small_region_select_in(cfg[4]),
		.top_bottom_select_in(cfg[3]), .block_protect_level_2_in(cfg[2]), .block_protect_level_1_in(cfg[1]),
		.block_protect_level_0_in(cfg[0]), .tx_en_in(tx_en), .tx_data_in(tx_data), .opcode_out(opcode),
		.opcode_valid_out(op_valid), .rx_data_out(rx_data), .rx_valid_out(rx_valid), .tx_take_out(take),
		.selected_out(sel), .held_out(held), .pin_reset_out(pin_rst), .status_write_locked_out(locked),
		.region_scope_out(scope));
	sfpi_host i_sfpi_host (.clock_in(clock_in), .nrst_in(nrst_in), .pins(pins), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata));
	sfpi_monitor i_sfpi_monitor (.clock_in(clock_in), .nrst_in(nrst_in), .sclk(pins.sclk), .cs_n(pins.cs_n),
		.rst_n(pins.rst_n), .host_lane_oe_n(pins.host_lane_oe_n), .dev_lane_out(pins.dev_lane_out),
		.dev_lane_oe_n(pins.dev_lane_oe_n));
	// Clock
	always #12.5 clock_in = ~clock_in;
	// Record device pulses
	always @(posedge clock_in) begin
		if (op_valid) begin
			op_seen <= opcode;
		end
		if (rx_valid) begin
			rx_seen <= rx_data;
			rx_cnt <= rx_cnt + 1;
		end
		if (take) begin
			take_cnt <= take_cnt + 1;
		end
	end
	task automatic check(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clock_in);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_in);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clock_in);
		rd_s <= 1'b0;
		#1;
		d = rdata;
	endtask
	// One byte frame: c holds width, read, keep and clock idle fields
	task automatic xfer(input logic [7:0] c, input logic [7:0] t);
		int n;
		logic [7:0] s;
		wr(REG_TXD, t);
		wr(REG_CTRL, c | 8'h01);
		n = 0;
		s = 8'h01;
		while (s[0] !== 1'b0 && n < 200) begin
			rd(REG_STAT, s);
			n++;
		end
		check(n < 200, "frame never ended");
		repeat (8) @(posedge clock_in);
	endtask
	task automatic t_single();
		int t0;
		xfer(8'h10, 8'h02);
		check(op_seen === 8'h02, "opcode");
		xfer(8'h00, 8'hA5);
		check(rx_seen === 8'hA5, "write byte");
		xfer(8'h10, 8'h0B);
		tx_data <= 8'h96;
		tx_en <= 1'b1;
		t0 = take_cnt;
		xfer(8'h08, 8'h00);
		tx_en <= 1'b0;
		check(take_cnt - t0 === 2, "byte loads in single read");
		rd(REG_RXD, rv);
		check(rv === 8'h96, "single read");
		$display("test single done");
	endtask
	task automatic t_wide();
		logic [7:0] ops [4] = '{OP_DUAL_OUT, OP_DUAL_IO, OP_QUAD_OUT, OP_QUAD_IO};
		logic [7:0] w;
		cfg[7] <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			w = (i < 2) ? 8'h02 : 8'h04;
			xfer(8'h10, ops[i]);
			check(op_seen === ops[i], "wide opcode");
			if (i[0]) begin
				xfer(8'h10 | w, ops[i]);
				check(rx_seen === ops[i], "wide write");
			end
			tx_data <= 8'hC3 ^ ops[i];
			tx_en <= 1'b1;
			xfer(8'h08 | w, 8'h00);
			tx_en <= 1'b0;
			rd(REG_RXD, rv);
			check(rv === (8'hC3 ^ ops[i]), "wide read");
		end
		cfg[7] <= 1'b0;
		xfer(8'h10, OP_QUAD_OUT);
		tx_data <= 8'h12;
		tx_en <= 1'b1;
		xfer(8'h0C, 8'h00);
		tx_en <= 1'b0;
		rd(REG_RXD, rv);
		check(rv === 8'hFF, "quad read without enable");
		$display("test wide done");
	endtask
	task automatic t_hold();
		int c0;
		xfer(8'h10, 8'h02);
		wr(REG_PIN, 8'h01);
		repeat (4) @(posedge clock_in);
		check(held === 1'b1, "hold not taken");
		c0 = rx_cnt;
		xfer(8'h10, 8'h3C);
		check(rx_cnt === c0, "byte taken while held");
		cfg[7] <= 1'b1;
		repeat (4) @(posedge clock_in);
		check(held === 1'b0, "hold honoured with quad enable");
		cfg[7] <= 1'b0;
		wr(REG_PIN, 8'h03);
		xfer(8'h00, 8'hC3);
		check(rx_seen === 8'hC3 && rx_cnt === c0 + 1, "resume after hold");
		$display("test hold done");
	endtask
	task automatic t_protect();
		cfg <= 8'h6D;
		wr(REG_PIN, 8'h02);
		repeat (6) @(posedge clock_in);
		check(locked === 1'b1 && scope === 6'h2D, "lock");
		wr(REG_PIN, 8'h03);
		repeat (6) @(posedge clock_in);
		check(locked === 1'b0 && scope === 6'h00, "unlock");
		cfg <= 8'hED;
		wr(REG_PIN, 8'h02);
		repeat (6) @(posedge clock_in);
		check(locked === 1'b0, "lock in quad");
		wr(REG_PIN, 8'h03);
		cfg <= 8'h00;
		$display("test protect done");
	endtask
	task automatic t_pinrst();
		int n;
		int c0;
		xfer(8'h10, 8'h06);
		wr(REG_PIN, 8'h07);
		n = 0;
		while (pin_rst !== 1'b1 && n < 80) begin
			@(posedge clock_in);
			n++;
		end
		check(n < 80, "pin reset not seen");
		repeat (2) @(posedge clock_in);
		check(sel === 1'b0, "frame not aborted");
		repeat (40) @(posedge clock_in);
		c0 = rx_cnt;
		xfer(8'h00, 8'h55);
		check(rx_cnt === c0, "taken without select fall");
		xfer(8'h00, 8'h9F);
		check(op_seen === 8'h9F, "opcode after reset");
		$display("test pin reset done");
	endtask
	task automatic t_mode3();
		wr(REG_CTRL, 8'h20);
		repeat (8) @(posedge clock_in);
		xfer(8'h30, 8'h81);
		check(op_seen === 8'h81, "mode 3 opcode");
		xfer(8'h20, 8'h7E);
		check(rx_seen === 8'h7E, "mode 3 byte");
		wr(REG_CTRL, 8'h00);
		$display("test mode 3 done");
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		#(CLK_NS * 40000);
		num_errors++;
		$display("unexpected at %0t: watchdog expired", $time);
		results();
	end
	// Main sequence
	initial begin
		repeat (5) @(posedge clock_in);
		nrst_in <= 1'b1;
		t_single();
		t_wide();
		t_hold();
		t_protect();
		t_pinrst();
		t_mode3();
		results();
	end
endmodule // tb_top
`default_nettype wire
